/* hdl/aite_pkg.sv */
// constants, register layout and state types of the timing engine
package aite_pkg;

  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_CFG  = 8'h04;
  localparam logic [7:0] A_PINS = 8'h08;
  localparam logic [7:0] A_SDIV = 8'h0C;
  localparam logic [7:0] A_SDLY = 8'h10;
  localparam logic [7:0] A_CDIV = 8'h14;
  localparam logic [7:0] A_CDLY = 8'h18;
  localparam logic [7:0] A_NCH  = 8'h1C;
  localparam logic [7:0] A_POST = 8'h20;
  localparam logic [7:0] A_PRE  = 8'h24;
  localparam logic [7:0] A_STAT = 8'h28;

  // ----------------------------------------
  // control bits, reset values, encodings
  // ----------------------------------------
  localparam int         C_START = 0;
  localparam int         C_SWSMP = 1;
  localparam int         C_ABORT = 2;
  localparam logic [15:0] R_SDLY = 16'h0002;
  localparam logic [15:0] R_CDLY = 16'h0003;
  localparam logic [15:0] R_DIV  = 16'h0002;
  localparam logic [4:0]  R_NCH  = 5'h01;
  localparam logic [1:0] SS_DIV  = 2'h0;
  localparam logic [1:0] SS_CTR  = 2'h1;
  localparam logic [1:0] SS_SW   = 2'h2;
  localparam logic [1:0] TB_20M  = 2'h0;
  localparam logic [1:0] TB_100K = 2'h1;
  localparam logic [1:0] CS_DIV  = 2'h0;
  localparam logic [1:0] CS_CTR  = 2'h1;

  // ----------------------------------------
  // timebases from the 50 MHz system clock
  // ----------------------------------------
  localparam int SYS_HZ     = 50_000_000;
  localparam int FAST_HZ    = 20_000_000;
  localparam int SLOW_HZ    = 100_000;
  localparam int STEP_HZ    = 10_000_000;
  localparam logic [2:0] ACC_INC = 3'(FAST_HZ / STEP_HZ);
  localparam logic [2:0] ACC_MOD = 3'(SYS_HZ / STEP_HZ);
  localparam logic [8:0] SLOW_LAST = 9'(SYS_HZ / SLOW_HZ - 1);

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_PRE   = 4'b0010,
    ST_ARMED = 4'b0100,
    ST_POST  = 4'b1000
  } acq_e;

  typedef struct packed {
    logic [13:0] rsvd;
    logic        st_edge;
    logic        st_ext;
    logic        rt_edge;
    logic        out_level;
    logic        pause_pol;
    logic        pause_en;
    logic        ctb_sel;
    logic        conv_edge;
    logic [1:0]  conv_src;
    logic        tb_edge;
    logic [1:0]  tb_sel;
    logic        samp_edge;
    logic [1:0]  samp_src;
    logic        pre_mode;
    logic        cont;
  } cfg_s;

  typedef struct packed {
    logic [5:0] rsvd;
    logic [1:0] out_en;
    logic [2:0] st_out;
    logic [2:0] smp_out;
    logic [2:0] st_pin;
    logic [2:0] pause_pin;
    logic [2:0] ref_pin;
    logic [2:0] conv_pin;
    logic [2:0] tb_pin;
    logic [2:0] smp_pin;
  } pins_s;

  typedef struct packed {
    cfg_s        cfg;
    pins_s       pins;
    logic [15:0] sdiv_r;
    logic [15:0] sdly_r;
    logic [15:0] cdiv_r;
    logic [15:0] cdly_r;
    logic [15:0] post_r;
    logic [15:0] pre_r;
    logic [4:0]  nch;
    acq_e        st;
    logic [15:0] cnt;
    logic [15:0] sdiv;
    logic [15:0] cdiv;
    logic        in_smp;
    logic [4:0]  cleft;
    logic [4:0]  chan;
    logic [4:0]  cidx;
    logic        done;
    logic [15:0] pin_p;
    logic        ctr_p;
    logic [8:0]  slow;
    logic [2:0]  acc;
    logic        dph;
    logic        dwr;
    logic [7:0]  dadr;
    logic [31:0] rdata;
    logic        rdy;
    logic [15:0] pfo;
    logic [15:0] pfoe;
    logic        conv;
    logic        busy;
  } st_s;

  // ----------------------------------------
  // pin maps and edge test
  // ----------------------------------------
  // inputs only from pins 0..3 and 8..11
  function automatic logic [3:0] in_pin(input logic [2:0] sel);
    return {sel[2], 1'b0, sel[1:0]};
  endfunction

  // outputs only to pins 4..7 and 12..15
  function automatic logic [3:0] out_pin(input logic [2:0] sel);
    return {sel[2], 1'b1, sel[1:0]};
  endfunction

  function automatic logic edge_of(input logic cur, input logic prv,
                                   input logic fall);
    return fall ? (prv & ~cur) : (cur & ~prv);
  endfunction

endpackage

/* hdl/pin_sync.sv */
// three-stage synchroniser with agreement filter for the function pins
`timescale 1ns/1ps
module pin_sync (
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  // pins
  input  wire logic [15:0] raw_i,
  output logic      [15:0] lvl_o
);

  logic [15:0] s1_q;
  logic [15:0] s2_q;
  logic [15:0] s3_q;
  logic [15:0] lvl_q;

  // ----------------------------------------
  // stages
  // ----------------------------------------
  // a change counts only once stages two and three agree
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      s1_q  <= 16'h0000;
      s2_q  <= 16'h0000;
      s3_q  <= 16'h0000;
      lvl_q <= 16'h0000;
    end else begin
      s1_q  <= raw_i;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      lvl_q <= (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
    end
  end

  assign lvl_o = lvl_q;

endmodule // pin_sync

/* hdl/analog_input_timing_engine.sv */
// acquisition timing engine: sample and conversion pulse sequencing
//
// Behaviour
// - posttrigger count loaded, decremented, ends at zero
// - pretrigger count first, then posttrigger count
// - stop trigger ignored before pretrigger samples
// - after stop trigger, count posttrigger samples, stop
// - software start emits start output pulse
// - one conversion per scan channel per sample
// - sample source internal or external, either edge
// - internal: counter, software, or divided timebase
// - external sample pulse from pins 0-3, 8-11
// - sample output on pins 4-7, 12-15, pulsed
// - level mode holds output high whole sample
// - sample pulses ignored when idle or paused
// - start trigger starts divider; completion stops it
// - start to first sample delay, default two
// - sample timebase 20 MHz, 100 kHz or pin
// - sample timebase never routed to pins
// - each conversion pulse converts one channel
// - conversion source internal or external, either edge
// - conversion divider restarts per sample, repeats
// - internal conversion: counter or divided timebase
// - external conversion pulse from pins 0-3, 8-11
// - sample to first conversion delay, default three
// - sample pulses ignored until conversions complete
// - conversions ignored outside a sample
// - pause gate halts internal sample divider
`timescale 1ns/1ps
module analog_input_timing_engine (
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  // ahb-lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // function pins
  input  wire logic [15:0] pfi_i,
  output logic      [15:0] pfi_o,
  output logic      [15:0] pfi_oe_o,
  // internal counter output
  input  wire logic        ctr_out_i,
  // converter side
  output logic             conv_start_o,
  output logic      [4:0]  chan_idx_o,
  output logic             acq_busy_o,
  output logic             acq_done_o
);

  aite_pkg::st_s s_q;
  aite_pkg::st_s s_d;
  logic [15:0]   pin_s;
  logic          start_evt;
  logic          samp_acc;
  logic          conv_acc;
  logic          ref_evt;
  logic          abort;
  logic          paused;

  pin_sync pin_sync_inst (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .raw_i     (pfi_i),
    .lvl_o     (pin_s)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic       aph;
    logic       wr;
    logic       sw_start;
    logic       sw_smp;
    logic       fast_t;
    logic       slow_t;
    logic       tb_t;
    logic       ctb_t;
    logic       div_p;
    logic       cdiv_p;
    logic       raw_s;
    logic       raw_c;
    logic       smp_v;
    logic [3:0] acc4;
    aph      = 1'b0;
    wr       = 1'b0;
    sw_start = 1'b0;
    sw_smp   = 1'b0;
    fast_t   = 1'b0;
    slow_t   = 1'b0;
    tb_t     = 1'b0;
    ctb_t    = 1'b0;
    div_p    = 1'b0;
    cdiv_p   = 1'b0;
    raw_s    = 1'b0;
    raw_c    = 1'b0;
    smp_v    = 1'b0;
    acc4     = 4'h0;
    s_d      = s_q;
    s_d.rdy  = 1'b1;
    s_d.conv = 1'b0;

    // bus: address phase taken, write in data phase
    aph = hsel_i && hready_i && htrans_i[1];
    wr  = s_q.dph && s_q.dwr;
    sw_start = wr && s_q.dadr == aite_pkg::A_CTRL
               && hwdata_i[aite_pkg::C_START];
    sw_smp   = wr && s_q.dadr == aite_pkg::A_CTRL
               && hwdata_i[aite_pkg::C_SWSMP];
    abort    = wr && s_q.dadr == aite_pkg::A_CTRL
               && hwdata_i[aite_pkg::C_ABORT];
    if (wr) begin
      case (s_q.dadr)
        aite_pkg::A_CFG: begin
          s_d.cfg      = aite_pkg::cfg_s'(hwdata_i);
          s_d.cfg.rsvd = 14'h0000;
        end
        aite_pkg::A_PINS: begin
          s_d.pins      = aite_pkg::pins_s'(hwdata_i);
          s_d.pins.rsvd = 6'h00;
        end
        aite_pkg::A_SDIV: s_d.sdiv_r = hwdata_i[15:0];
        aite_pkg::A_SDLY: s_d.sdly_r = hwdata_i[15:0];
        aite_pkg::A_CDIV: s_d.cdiv_r = hwdata_i[15:0];
        aite_pkg::A_CDLY: s_d.cdly_r = hwdata_i[15:0];
        aite_pkg::A_NCH:  s_d.nch    = hwdata_i[4:0];
        aite_pkg::A_POST: s_d.post_r = hwdata_i[15:0];
        aite_pkg::A_PRE:  s_d.pre_r  = hwdata_i[15:0];
        default: ;
      endcase
    end

    // timebases as enables; the accumulator gives 2 ticks per 5 clocks
    acc4 = {1'b0, s_q.acc} + {1'b0, aite_pkg::ACC_INC};
    fast_t = acc4 >= {1'b0, aite_pkg::ACC_MOD};
    s_d.acc = fast_t ? 3'(acc4 - {1'b0, aite_pkg::ACC_MOD})
                     : acc4[2:0];
    slow_t = s_q.slow == aite_pkg::SLOW_LAST;
    s_d.slow = slow_t ? 9'h000 : s_q.slow + 9'h001;
    case (s_q.cfg.tb_sel)
      aite_pkg::TB_20M:  tb_t = fast_t;
      aite_pkg::TB_100K: tb_t = slow_t;
      default: tb_t = aite_pkg::edge_of(
          pin_s[aite_pkg::in_pin(s_q.pins.tb_pin)],
          s_q.pin_p[aite_pkg::in_pin(s_q.pins.tb_pin)],
          s_q.cfg.tb_edge);
    endcase
    ctb_t = s_q.cfg.ctb_sel ? fast_t : tb_t;

    paused = s_q.cfg.pause_en
             && pin_s[aite_pkg::in_pin(s_q.pins.pause_pin)]
                == s_q.cfg.pause_pol;
    start_evt = s_q.st == aite_pkg::ST_IDLE && !abort
                && (s_q.cfg.st_ext
                    ? aite_pkg::edge_of(
                        pin_s[aite_pkg::in_pin(s_q.pins.st_pin)],
                        s_q.pin_p[aite_pkg::in_pin(s_q.pins.st_pin)],
                        s_q.cfg.st_edge)
                    : sw_start);
    ref_evt = aite_pkg::edge_of(
        pin_s[aite_pkg::in_pin(s_q.pins.ref_pin)],
        s_q.pin_p[aite_pkg::in_pin(s_q.pins.ref_pin)],
        s_q.cfg.rt_edge);

    // start delay, then divider runs only while busy
    if (start_evt) begin
      s_d.sdiv = s_q.sdly_r;
    end else if (s_q.st != aite_pkg::ST_IDLE && !paused && tb_t
                 && s_q.cfg.samp_src == aite_pkg::SS_DIV) begin
      if (s_q.sdiv <= 16'h0001) begin
        div_p    = 1'b1;
        s_d.sdiv = s_q.sdiv_r;
      end else begin
        s_d.sdiv = s_q.sdiv - 16'h0001;
      end
    end

    case (s_q.cfg.samp_src)
      aite_pkg::SS_DIV: raw_s = div_p;
      aite_pkg::SS_CTR: raw_s = aite_pkg::edge_of(ctr_out_i, s_q.ctr_p,
                                                  s_q.cfg.samp_edge);
      aite_pkg::SS_SW:  raw_s = sw_smp;
      default: raw_s = aite_pkg::edge_of(
          pin_s[aite_pkg::in_pin(s_q.pins.smp_pin)],
          s_q.pin_p[aite_pkg::in_pin(s_q.pins.smp_pin)],
          s_q.cfg.samp_edge);
    endcase
    // gating; a too fast source just loses pulses
    samp_acc = raw_s && s_q.st != aite_pkg::ST_IDLE && !paused
               && !s_q.in_smp && !abort
               && !(s_q.st == aite_pkg::ST_POST && s_q.cnt == 16'h0000);

    if (samp_acc) begin
      case (s_q.st)
        aite_pkg::ST_PRE: begin
          s_d.cnt = s_q.cnt - 16'h0001;
          if (s_q.cnt <= 16'h0001) begin
            s_d.st = aite_pkg::ST_ARMED;
          end
        end
        aite_pkg::ST_POST: begin
          if (!s_q.cfg.cont) begin
            s_d.cnt = s_q.cnt - 16'h0001;
          end
        end
        default: ;
      endcase
    end
    if (s_q.st == aite_pkg::ST_ARMED && ref_evt) begin
      s_d.st  = aite_pkg::ST_POST;
      s_d.cnt = s_q.post_r;
    end
    // finish once the last sample converted
    if (s_q.st == aite_pkg::ST_POST && s_q.cnt == 16'h0000
        && !s_q.in_smp && !s_q.cfg.cont) begin
      s_d.st   = aite_pkg::ST_IDLE;
      s_d.done = 1'b1;
    end
    if (start_evt) begin
      s_d.done = 1'b0;
      if (!s_q.cfg.pre_mode) begin
        s_d.st  = aite_pkg::ST_POST;
        s_d.cnt = s_q.post_r;
      end else begin
        s_d.st  = s_q.pre_r == 16'h0000 ? aite_pkg::ST_ARMED
                                        : aite_pkg::ST_PRE;
        s_d.cnt = s_q.pre_r;
      end
    end

    if (s_q.in_smp && ctb_t && s_q.cfg.conv_src == aite_pkg::CS_DIV) begin
      if (s_q.cdiv <= 16'h0001) begin
        cdiv_p   = 1'b1;
        s_d.cdiv = s_q.cdiv_r;
      end else begin
        s_d.cdiv = s_q.cdiv - 16'h0001;
      end
    end
    case (s_q.cfg.conv_src)
      aite_pkg::CS_DIV: raw_c = cdiv_p;
      aite_pkg::CS_CTR: raw_c = aite_pkg::edge_of(ctr_out_i, s_q.ctr_p,
                                                  s_q.cfg.conv_edge);
      default: raw_c = aite_pkg::edge_of(
          pin_s[aite_pkg::in_pin(s_q.pins.conv_pin)],
          s_q.pin_p[aite_pkg::in_pin(s_q.pins.conv_pin)],
          s_q.cfg.conv_edge);
    endcase
    conv_acc = raw_c && s_q.in_smp;
    if (conv_acc) begin
      s_d.conv  = 1'b1;
      s_d.cidx  = s_q.chan;
      s_d.chan  = s_q.chan + 5'h01;
      s_d.cleft = s_q.cleft - 5'h01;
      if (s_q.cleft <= 5'h01) begin
        s_d.in_smp = 1'b0;
      end
    end
    // a sample opens the scan list
    if (samp_acc) begin
      s_d.in_smp = 1'b1;
      s_d.cleft  = s_q.nch;
      s_d.chan   = 5'h00;
      s_d.cdiv   = s_q.cdly_r;
    end
    if (abort) begin
      s_d.st     = aite_pkg::ST_IDLE;
      s_d.in_smp = 1'b0;
    end

    // routed outputs; timebase has no route
    smp_v    = s_q.cfg.out_level ? s_d.in_smp : samp_acc;
    s_d.pfo  = 16'h0000;
    s_d.pfoe = 16'h0000;
    if (s_q.pins.out_en[0]) begin
      s_d.pfo[aite_pkg::out_pin(s_q.pins.smp_out)]  = smp_v;
      s_d.pfoe[aite_pkg::out_pin(s_q.pins.smp_out)] = 1'b1;
    end
    if (s_q.pins.out_en[1]) begin
      s_d.pfo[aite_pkg::out_pin(s_q.pins.st_out)]  =
        s_d.pfo[aite_pkg::out_pin(s_q.pins.st_out)] | start_evt;
      s_d.pfoe[aite_pkg::out_pin(s_q.pins.st_out)] = 1'b1;
    end
    s_d.busy  = s_d.st != aite_pkg::ST_IDLE;
    s_d.pin_p = pin_s;
    s_d.ctr_p = ctr_out_i;

    // read data registered at the address phase, after any write
    s_d.dph = aph;
    s_d.dwr = hwrite_i;
    s_d.dadr = haddr_i[7:0];
    if (aph && !hwrite_i) begin
      case (haddr_i[7:0])
        aite_pkg::A_CFG:  s_d.rdata = 32'(s_d.cfg);
        aite_pkg::A_PINS: s_d.rdata = 32'(s_d.pins);
        aite_pkg::A_SDIV: s_d.rdata = {16'h0000, s_d.sdiv_r};
        aite_pkg::A_SDLY: s_d.rdata = {16'h0000, s_d.sdly_r};
        aite_pkg::A_CDIV: s_d.rdata = {16'h0000, s_d.cdiv_r};
        aite_pkg::A_CDLY: s_d.rdata = {16'h0000, s_d.cdly_r};
        aite_pkg::A_NCH:  s_d.rdata = {27'h0000000, s_d.nch};
        aite_pkg::A_POST: s_d.rdata = {16'h0000, s_d.post_r};
        aite_pkg::A_PRE:  s_d.rdata = {16'h0000, s_d.pre_r};
        aite_pkg::A_STAT: s_d.rdata = {s_q.cnt, 8'h00, s_q.st,
                                       1'b0, s_q.in_smp, s_q.done,
                                       s_q.busy};
        default: s_d.rdata = 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      s_q        <= '0;
      s_q.st     <= aite_pkg::ST_IDLE;
      s_q.sdly_r <= aite_pkg::R_SDLY;
      s_q.cdly_r <= aite_pkg::R_CDLY;
      s_q.sdiv_r <= aite_pkg::R_DIV;
      s_q.cdiv_r <= aite_pkg::R_DIV;
      s_q.nch    <= aite_pkg::R_NCH;
      s_q.rdy    <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign hrdata_o     = s_q.rdata;
  assign hreadyout_o  = s_q.rdy;
  assign hresp_o      = 1'b0;
  assign pfi_o        = s_q.pfo;
  assign pfi_oe_o     = s_q.pfoe;
  assign conv_start_o = s_q.conv;
  assign chan_idx_o   = s_q.cidx;
  assign acq_busy_o   = s_q.busy;
  assign acq_done_o   = s_q.done;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_post_load;
    start_evt && !s_q.cfg.pre_mode |=>
      s_q.st == aite_pkg::ST_POST && s_q.cnt == $past(s_q.post_r);
  endproperty
  a_post_load: assert property (p_post_load)
    else $error("posttrigger load wrong");

  property p_pre_load;
    start_evt && s_q.cfg.pre_mode && s_q.pre_r != 16'h0000 |=>
      s_q.st == aite_pkg::ST_PRE && s_q.cnt == $past(s_q.pre_r);
  endproperty
  a_pre_load: assert property (p_pre_load)
    else $error("pretrigger load wrong");

  property p_ref_early;
    s_q.st == aite_pkg::ST_PRE |=> s_q.st != aite_pkg::ST_POST;
  endproperty
  a_ref_early: assert property (p_ref_early)
    else $error("early stop trigger taken");

  property p_ref_take;
    s_q.st == aite_pkg::ST_ARMED && ref_evt && !abort |=>
      s_q.st == aite_pkg::ST_POST && s_q.cnt == $past(s_q.post_r);
  endproperty
  a_ref_take: assert property (p_ref_take)
    else $error("stop trigger not taken");

  property p_start_out;
    start_evt && !s_q.cfg.st_ext && s_q.pins.out_en[1] |=>
      s_q.pfo[aite_pkg::out_pin(s_q.pins.st_out)];
  endproperty
  a_start_out: assert property (p_start_out)
    else $error("no start output pulse");

  property p_scan_len;
    samp_acc |=> s_q.in_smp && s_q.cleft == $past(s_q.nch);
  endproperty
  a_scan_len: assert property (p_scan_len)
    else $error("scan length not loaded");

  property p_idle_ign;
    s_q.st == aite_pkg::ST_IDLE && !s_q.in_smp |=> !s_q.in_smp;
  endproperty
  a_idle_ign: assert property (p_idle_ign)
    else $error("sample taken while idle");

  property p_busy_ign;
    s_q.in_smp && !conv_acc && !abort |=>
      s_q.in_smp && s_q.cleft == $past(s_q.cleft);
  endproperty
  a_busy_ign: assert property (p_busy_ign)
    else $error("sample restarted mid-scan");

  property p_conv_ign;
    !s_q.in_smp |=> !s_q.conv;
  endproperty
  a_conv_ign: assert property (p_conv_ign)
    else $error("conversion outside sample");

  property p_sdly;
    start_evt && s_q.cfg.samp_src == aite_pkg::SS_DIV |=>
      s_q.sdiv == s_q.sdly_r;
  endproperty
  a_sdly: assert property (p_sdly)
    else $error("start delay not loaded");

  property p_done;
    s_q.st == aite_pkg::ST_POST && s_q.cnt == 16'h0000 && !s_q.in_smp
      && !s_q.cfg.cont && !start_evt |=>
      s_q.done && s_q.st == aite_pkg::ST_IDLE ##1 !s_q.in_smp;
  endproperty
  a_done: assert property (p_done)
    else $error("done not raised");

  c_pre_armed: cover property (s_q.st == aite_pkg::ST_PRE
                               ##[1:1000] s_q.st == aite_pkg::ST_ARMED);
  c_done: cover property ($rose(s_q.done));
  c_pause: cover property (paused && s_q.st == aite_pkg::ST_POST);

endmodule // analog_input_timing_engine

/* tb/pin_source.sv */
// partner model: trigger source on a function pin
`timescale 1ns/1ps
module pin_source (
  // clock
  input  wire logic        sys_clk_i,
  // request
  input  wire logic        fire_i,
  // pins
  output logic      [15:0] pin_o
);
  logic [3:0] hold_q = 4'h0;

  always_ff @(posedge sys_clk_i) begin
    if (fire_i) begin
      hold_q <= 4'h6;
    end else if (hold_q != 4'h0) begin
      hold_q <= hold_q - 4'h1;
    end
  end

  // idle low between pulses, active high while held
  assign pin_o = {15'h0000, hold_q != 4'h0};
endmodule // pin_source

/* tb/analog_input_timing_engine_tb.sv */
// self-checking bench for the acquisition timing engine
`timescale 1ns/1ps
module analog_input_timing_engine_tb;
  logic        sys_clk = 1'b0;
  logic        rst_n   = 1'b0;
  logic        hsel    = 1'b0;
  logic [31:0] haddr   = 32'h0;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'b0;
  logic [31:0] hwdata  = 32'h0;
  logic        ctr     = 1'b0;
  logic        fire    = 1'b0;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic        busy;
  logic        done;
  logic [15:0] pfo;
  logic [15:0] pfoe;
  logic [15:0] src;
  logic [15:0] pins;
  logic        conv_start;
  logic [4:0]  chan;
  logic [4:0]  nch;
  integer      seed    = 32'h19D69C3D;
  logic [4:0]  exp_q[$];
  logic [1:0]  prv     = 2'h0;
  int          num_errors = 0;
  int          num_checks = 0;
  int          spc     = 0;
  int          stc     = 0;

  // enabled outputs win over the partner
  assign pins = (pfoe & pfo) | (~pfoe & src);

  analog_input_timing_engine analog_input_timing_engine_inst (
    .sys_clk_i(sys_clk), .rst_n_i(rst_n), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(hresp), .pfi_i(pins), .pfi_o(pfo),
    .pfi_oe_o(pfoe), .ctr_out_i(ctr), .conv_start_o(conv_start),
    .chan_idx_o(chan), .acq_busy_o(busy), .acq_done_o(done));

  pin_source pin_source_inst (.sys_clk_i(sys_clk), .fire_i(fire),
                              .pin_o(src));

  initial forever #10 sys_clk = ~sys_clk;

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string msg);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s: got %h want %h", $time, msg, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // no wait-state count assumed: wait for hready each phase
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge sys_clk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge sys_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hready !== 1'b1);
    r = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    check(r, e, "register read");
    check(32'(hresp), 32'h0, "response");
  endtask

  task automatic conv(input int n);
    repeat (n) begin
      @(posedge sys_clk) ctr <= 1'b1;
      @(posedge sys_clk) ctr <= 1'b0;
      repeat (2) @(posedge sys_clk);
    end
  endtask

  // dup adds a mid-scan sample pulse and one excess conversion
  task automatic smp(input int dup);
    for (int i = 0; i < nch; i++) exp_q.push_back(5'(i));
    wr(aite_pkg::A_CTRL, 32'h2);
    if (dup != 0) wr(aite_pkg::A_CTRL, 32'h2);
    conv(nch + dup);
  endtask

  task automatic trig;
    @(posedge sys_clk) fire <= 1'b1;
    @(posedge sys_clk) fire <= 1'b0;
    repeat (10) @(posedge sys_clk);
  endtask

  // ----------------------------------------
  // monitor, stimulus, watchdog
  // ----------------------------------------
  always @(posedge sys_clk) begin
    prv <= pfo[5:4];
    if (pfo[4] === 1'b1 && prv[0] === 1'b0) spc++;
    if (pfo[5] === 1'b1 && prv[1] === 1'b0) stc++;
    if (conv_start === 1'b1) begin
      if (exp_q.size() == 0)
        check(32'h1, 32'h0, "stray conversion");
      else
        check({27'h0, chan}, {27'h0, exp_q.pop_front()}, "chan");
    end
  end

  initial begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rd(aite_pkg::A_SDLY, 32'h2);
    rd(aite_pkg::A_CDLY, 32'h3);
    rd(aite_pkg::A_NCH, 32'h1);
    rd(8'h3C, 32'h0);
    nch = 5'(1 + ($random(seed) & 3));
    wr(aite_pkg::A_NCH, {27'h0, nch});
    wr(aite_pkg::A_POST, 32'h2);
    wr(aite_pkg::A_CFG, 32'h108);
    wr(aite_pkg::A_PINS, 32'h0320_0000);
    conv(1);
    wr(aite_pkg::A_CTRL, 32'h1);
    smp(1);
    smp(1);
    rd(aite_pkg::A_STAT, 32'h12);
    wr(aite_pkg::A_CTRL, 32'h2);
    conv(1);
    wr(aite_pkg::A_PRE, 32'h1);
    wr(aite_pkg::A_POST, 32'h1);
    wr(aite_pkg::A_CFG, 32'h10A);
    wr(aite_pkg::A_CTRL, 32'h1);
    rd(aite_pkg::A_STAT, 32'h0001_0021);
    trig;
    rd(aite_pkg::A_STAT, 32'h0001_0021);
    smp(0);
    rd(aite_pkg::A_STAT, 32'h41);
    trig;
    rd(aite_pkg::A_STAT, 32'h0001_0081);
    smp(0);
    rd(aite_pkg::A_STAT, 32'h12);
    // internal dividers, paused first, level output
    wr(aite_pkg::A_CFG, 32'h5000);
    for (int i = 0; i < nch; i++) exp_q.push_back(5'(i));
    wr(aite_pkg::A_CTRL, 32'h1);
    repeat (40) @(posedge sys_clk);
    rd(aite_pkg::A_STAT, 32'h0001_0081);
    check(32'({busy, done}), 32'h2, "busy done");
    wr(aite_pkg::A_CFG, 32'h4000);
    repeat (60) @(posedge sys_clk);
    rd(aite_pkg::A_STAT, 32'h12);
    check(32'({busy, done}), 32'h1, "busy done");
    check(32'(pfoe), 32'h30, "pin enables");
    check(32'(spc), 32'h5, "sample out pulses");
    check(32'(stc), 32'h3, "start out pulses");
    check(32'(exp_q.size()), 32'h0, "missing conversions");
    tally_and_finish;
  end

  // whole run is a few hundred cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    check(32'h1, 32'h0, "timeout");
    tally_and_finish;
  end
endmodule // analog_input_timing_engine_tb
